// File: hw/sfl_fault_latch.sv
// Fault latch, indicator and relay logic of the signal conflict monitor
`timescale 1ns/1ns
module sfl_fault_latch import sfl_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Cabinet and controller pins
  input wire sfl_pins_type pins,
  // Nonvolatile record store
  input wire logic nv_rd_valid,
  input wire sfl_record_type nv_rd_rec,
  output logic nv_wr_en,
  output sfl_record_type nv_wr_rec,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Failsafe outputs
  output logic relay_coil,
  output logic stop_time_o,
  output logic stop_time_oe_n,
  // Front panel
  output sfl_ind_type ind,
  output logic [NUM_CH-1:0] chan_ind
);

  function automatic logic [10:0] persist(input logic cond, input logic tick, input logic [10:0] c);
    logic [10:0] n;
    n = c;
    if (!cond) begin
      n = 11'h000;
    end else if (tick && c != 11'h7ff) begin
      n = c + 11'h001;
    end
    return n;
  endfunction

  sfl_pins_type s1_q, s2_q;
  logic btn3_q, ext3_q, wd3_q, cpu3_q;
  logic [17:0] ms_cnt_q;
  logic ms_tick;
  logic [10:0] flash_ms_q;
  logic flash_q;
  logic [10:0] red_ms_q, conf_ms_q, multi_ms_q, none_ms_q, wd_ms_q, cpu_ms_q;
  logic wd_en_q;
  logic [NUM_CH-1:0] sel_q, yinh_q;
  logic [11:0] minyel_q;
  logic rst_done_q, failed_q;
  sfl_cause_type cause_q, trips;
  logic [NUM_CH-1:0] snap_g_q, snap_y_q, snap_r_q, fail_ch_q;
  logic [NUM_CH-1:0] y_m, active, conf_ch, multi_ch, none_ch, yel_ch, fail_ch_d;
  logic red_ok, ext_on, rst_edge, latch_now;
  logic [1:0] live_q;

  // Two-stage capture of all cabinet pins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      btn3_q <= 1'b0;
      ext3_q <= 1'b0;
      wd3_q <= 1'b0;
      cpu3_q <= 1'b0;
    end else begin
      btn3_q <= s2_q.reset_btn;
      ext3_q <= s2_q.ext_reset;
      wd3_q <= s2_q.ctrl_wd;
      cpu3_q <= s2_q.cpu_alive;
    end
  end

  // Captures read zero for two edges after reset; a dead supply or card seen there is not real,
  // and a button held through reset must not look like a fresh press
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      live_q <= 2'h0;
    end else begin
      live_q <= {live_q[0], rst_done_q};
    end
  end

  // Leading edge only, so a stuck button or line cannot hold reset
  assign rst_edge = live_q[1] && ((s2_q.reset_btn && !btn3_q) || (s2_q.ext_reset && !ext3_q));

  // Millisecond tick shared by every timer
  assign ms_tick = (ms_cnt_q == 18'(MS_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ms_cnt_q <= 18'h00000;
    end else begin
      ms_cnt_q <= ms_tick ? 18'h00000 : ms_cnt_q + 18'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flash_ms_q <= 11'h000;
      flash_q <= 1'b0;
    end else if (ms_tick) begin
      if (flash_ms_q == 11'(FLASH_HALF_MS - 1)) begin
        flash_ms_q <= 11'h000;
        flash_q <= !flash_q;
      end else begin
        flash_ms_q <= flash_ms_q + 11'h001;
      end
    end
  end

  // Register port
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wd_en_q <= CTRL_WD_EN_RST;
      sel_q <= CH_SEL_RST;
      yinh_q <= YEL_INH_RST;
      minyel_q <= MIN_YEL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: wd_en_q <= reg_wdata[CTRL_WD_EN_BIT];
        REG_CH_SEL: sel_q <= reg_wdata[NUM_CH-1:0];
        REG_YEL_INH: yinh_q <= reg_wdata[NUM_CH-1:0];
        REG_MIN_YEL: minyel_q <= reg_wdata[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {31'h00000000, wd_en_q};
        REG_CH_SEL: reg_rdata <= {16'h0000, sel_q};
        REG_YEL_INH: reg_rdata <= {16'h0000, yinh_q};
        REG_MIN_YEL: reg_rdata <= {20'h00000, minyel_q};
        REG_STATUS: reg_rdata <= {21'h000000, s2_q.line_ok, red_ok, failed_q, cause_q};
        REG_SNAP_GY: reg_rdata <= {snap_y_q, snap_g_q};
        REG_SNAP_RC: reg_rdata <= {fail_ch_q, snap_r_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Yellow inputs dropped from all checks where inhibited
  assign y_m = s2_q.yel & ~yinh_q;
  assign active = s2_q.grn | y_m;

  // Cable must be seen for a settle time before extended checks start
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      red_ms_q <= 11'h000;
    end else begin
      red_ms_q <= persist(s2_q.red_monitor_cable_en, ms_tick, red_ms_q);
    end
  end

  assign red_ok = (red_ms_q >= 11'(RED_SETTLE_MS));
  assign ext_on = red_ok;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic pg_q, py_q;
    logic [11:0] yc_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        pg_q <= 1'b0;
        py_q <= 1'b0;
        yc_q <= 12'h000;
      end else begin
        pg_q <= s2_q.grn[i];
        py_q <= y_m[i];
        if (!y_m[i]) begin
          yc_q <= 12'h000;
        end else if (ms_tick && yc_q != 12'hfff) begin
          yc_q <= yc_q + 12'h001;
        end
      end
    end
    assign conf_ch[i] = active[i] && |(active & ~s2_q.compat[i] & ~(16'h0001 << i));
    assign multi_ch[i] = ext_on && sel_q[i] &&
      ((s2_q.grn[i] && y_m[i]) || (s2_q.grn[i] && s2_q.red[i]) || (y_m[i] && s2_q.red[i]));
    assign none_ch[i] = ext_on && sel_q[i] && !(s2_q.grn[i] || y_m[i] || s2_q.red[i]);
    assign yel_ch[i] = ext_on && sel_q[i] && !yinh_q[i] && s2_q.red[i] &&
      ((pg_q && !s2_q.grn[i] && !s2_q.yel[i]) || (py_q && !y_m[i] && yc_q < minyel_q));
  end

  // Persistence timers in milliseconds
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      conf_ms_q <= 11'h000;
      multi_ms_q <= 11'h000;
      none_ms_q <= 11'h000;
    end else begin
      conf_ms_q <= persist(|conf_ch, ms_tick, conf_ms_q);
      multi_ms_q <= persist(|multi_ch, ms_tick, multi_ms_q);
      none_ms_q <= persist(|none_ch, ms_tick, none_ms_q);
    end
  end

  // Controller watchdog and processor activity supervision
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wd_ms_q <= 11'h000;
      cpu_ms_q <= 11'h000;
    end else begin
      wd_ms_q <= persist(wd_en_q && (s2_q.ctrl_wd == wd3_q), ms_tick, wd_ms_q);
      cpu_ms_q <= persist(s2_q.cpu_alive == cpu3_q, ms_tick, cpu_ms_q);
    end
  end

  always_comb begin
    trips = '0;
    trips.conflict = (conf_ms_q >= 11'(CONFLICT_TRIP_MS));
    trips.dc_supply = !s2_q.dc_ok;
    trips.controller_wd = wd_en_q && (wd_ms_q >= 11'(WDT_TIMEOUT_MS));
    trips.card_unseated = !s2_q.card_seated;
    trips.multiple_input = (multi_ms_q >= 11'(PERSIST_MS));
    trips.no_input = (none_ms_q >= 11'(PERSIST_MS));
    trips.yellow_fault = |yel_ch;
    trips.internal_failure = s2_q.mem_test_fail || (cpu_ms_q >= 11'(CPU_TIMEOUT_MS));
  end

  always_comb begin
    fail_ch_d = '0;
    if (trips.conflict) begin
      fail_ch_d = fail_ch_d | active;
    end
    if (trips.multiple_input) begin
      fail_ch_d = fail_ch_d | multi_ch;
    end
    if (trips.no_input) begin
      fail_ch_d = fail_ch_d | none_ch;
    end
    if (trips.yellow_fault) begin
      fail_ch_d = fail_ch_d | yel_ch;
    end
  end

  // A new fault wins over a reset arriving in the same cycle
  assign latch_now = live_q[1] && (|trips) && (!failed_q || rst_edge);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_done_q <= 1'b0;
      failed_q <= 1'b0;
      cause_q <= '0;
      fail_ch_q <= '0;
      snap_g_q <= '0;
      snap_y_q <= '0;
      snap_r_q <= '0;
    end else if (!rst_done_q) begin
      rst_done_q <= 1'b1;
      if (nv_rd_valid && nv_rd_rec.failed) begin
        failed_q <= 1'b1;
        cause_q <= nv_rd_rec.cause;
        fail_ch_q <= nv_rd_rec.chan;
        snap_g_q <= nv_rd_rec.grn;
        snap_y_q <= nv_rd_rec.yel;
        snap_r_q <= nv_rd_rec.red;
      end
    end else if (latch_now) begin
      failed_q <= 1'b1;
      cause_q <= trips;
      fail_ch_q <= fail_ch_d;
      snap_g_q <= s2_q.grn;
      snap_y_q <= s2_q.yel;
      snap_r_q <= s2_q.red;
    end else if (rst_edge) begin
      failed_q <= 1'b0;
      cause_q <= '0;
      fail_ch_q <= '0;
    end
  end

  // Every latch and clear is written through to the record store
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nv_wr_en <= 1'b0;
      nv_wr_rec <= '0;
    end else begin
      nv_wr_en <= latch_now || (rst_done_q && failed_q && rst_edge);
      nv_wr_rec <= {latch_now, trips, fail_ch_d, s2_q.red, s2_q.yel, s2_q.grn};
    end
  end

  // Coil drops out on failure so the closed contacts start flashing
  assign relay_coil = !failed_q;
  assign stop_time_o = 1'b0;
  assign stop_time_oe_n = !failed_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ind <= '0;
      chan_ind <= '0;
    end else begin
      ind.line_power_indicator <= s2_q.line_ok || flash_q;
      ind.dc_supply_fault_indicator <= failed_q && cause_q.dc_supply;
      ind.conflict <= failed_q && cause_q.conflict;
      ind.controller_supervision_fault <= (failed_q && cause_q.controller_wd) ||
        (!failed_q && !wd_en_q && flash_q);
      ind.card_unseated <= (failed_q && cause_q.card_unseated) || !s2_q.card_seated;
      ind.multiple_input <= failed_q && cause_q.multiple_input;
      ind.no_active_input_fault <= (failed_q && cause_q.no_input) ||
        (!failed_q && !s2_q.red_monitor_cable_en && flash_q);
      ind.yellow_fault <= failed_q && cause_q.yellow_fault;
      ind.internal_failure <= failed_q && cause_q.internal_failure;
      chan_ind <= failed_q ? fail_ch_q : (active | s2_q.red);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_RELAY_FAILED: assert property (failed_q |-> !relay_coil)
    else $error("relay coil energized while failed");
  AST_STOP_TIME: assert property (relay_coil == stop_time_oe_n)
    else $error("halt output disagrees with failed state");
  AST_HOLD_LATCH: assert property (failed_q && !rst_edge |=> failed_q && $stable(fail_ch_q))
    else $error("failed state dropped without reset");
  AST_EDGE_ONLY: assert property (rst_edge |-> $rose(s2_q.reset_btn) || $rose(s2_q.ext_reset))
    else $error("reset taken without a rising edge");
  AST_SNAPSHOT: assert property (latch_now |=> snap_g_q == $past(s2_q.grn) && nv_wr_en && failed_q)
    else $error("snapshot or record write missing at latch");
  AST_RESTORE: assert property (rstn && !rst_done_q && nv_rd_valid && nv_rd_rec.failed |=> failed_q)
    else $error("stored failure not restored");
  AST_EXT_GATED: assert property (!s2_q.red_monitor_cable_en |-> ##1 !(|multi_ch) && !(|none_ch))
    else $error("extended check active without red enable");
  AST_CONFLICT_SHORT: assert property (trips.conflict |-> conf_ms_q > 11'(CONFLICT_PASS_MS))
    else $error("conflict tripped too early");
  AST_CONFLICT_LONG: assert property (conf_ms_q >= 11'(CONFLICT_FAIL_MS) && rst_done_q |=> failed_q)
    else $error("long conflict did not fail");
  AST_FLASH_DUTY: assert property ($changed(flash_q) |-> $past(ms_tick) &&
      $past(flash_ms_q) == 11'(FLASH_HALF_MS - 1))
    else $error("flash toggled off schedule");
  AST_LINE_IND: assert property (s2_q.line_ok |=> ind.line_power_indicator)
    else $error("line indicator dark with line present");
  AST_ONLY_CAUSE: assert property (failed_q |=> ind.conflict == $past(cause_q.conflict) &&
      ind.multiple_input == $past(cause_q.multiple_input) && ind.yellow_fault == $past(cause_q.yellow_fault))
    else $error("fault indicator disagrees with latched cause");
  AST_CARD_IND: assert property (live_q[1] && !s2_q.card_seated |=> ind.card_unseated)
    else $error("card indicator dark with card out");
  AST_DC_TRIP: assert property (live_q[1] && !s2_q.dc_ok |=> failed_q)
    else $error("supply failure did not latch");
  AST_RESET_CLEARS: assert property (failed_q && rst_edge && !(|trips) |=> !failed_q && relay_coil)
    else $error("clean reset edge did not clear");
  AST_WD_FLASH: assert property (!failed_q && !wd_en_q |=>
      ind.controller_supervision_fault == $past(flash_q))
    else $error("watchdog indicator not flashing while disabled");
  AST_NO_INPUT_FLASH: assert property (!failed_q && !s2_q.red_monitor_cable_en |=>
      ind.no_active_input_fault == $past(flash_q))
    else $error("no-input indicator not flashing without red enable");
  AST_NV_CLEAR: assert property (failed_q && rst_edge && !(|trips) |=> nv_wr_en && !nv_wr_rec.failed)
    else $error("clear not written to record store");
  AST_CHAN_SHOW: assert property (failed_q |=> chan_ind == $past(fail_ch_q))
    else $error("channel indicators differ from latched channels");

  COV_CONFLICT: cover property (latch_now && trips.conflict);
  COV_RESET_CLEAR: cover property (failed_q && rst_edge && !(|trips) ##1 !failed_q);
  COV_RESTORE: cover property (!rst_done_q && nv_rd_valid && nv_rd_rec.failed);
  COV_YELLOW: cover property (latch_now && trips.yellow_fault);
  COV_MULTI: cover property (latch_now && trips.multiple_input);

endmodule

// File: inc/sfl_pkg.sv
// Constants and types for the signal conflict fault latch
//
// Summary of operation
// - Relay coil energized only while not failed
// - Failed state drives active-low halt output
// - Failed state holds until valid reset
// - Reset only on rising edge of sources
// - Capture all channel inputs at latch, nonvolatile
// - Restore latched failure after power returns
// - Yellow monitoring can be suppressed per channel
// - Red cable plug events never force failure
// - Memory test or processor fault latches internal
// - Independent supervision checks processor activity
// - Extended checks need red enable, selected channels
// - Short yellow or green-to-red flags yellow fault
// - Only the causing fault indicator latches
// - Line indicator steady above threshold, else flashes
// - DC supply failure lights its indicator
// - Conflict lights indicator, shows active inputs
// - Watchdog fault steady; flashes when supervision disabled
// - Card unseated indicator while card not seated
// - Multiple inputs on flags fault with channel
// - No input flags fault; flashes without red enable
// - Without red enable only conflict, watchdog, DC, card, internal
// - Conflict lasting 450 ms always fails
// - Conflict of 200 ms or less never fails
package sfl_pkg;

  localparam int NUM_CH = 16;
  localparam int CLK_HZ = 250_000_000;
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000;

  // Times in milliseconds
  localparam int CONFLICT_FAIL_MS = 450;
  localparam int CONFLICT_PASS_MS = 200;
  localparam int CONFLICT_TRIP_MS = (CONFLICT_FAIL_MS + CONFLICT_PASS_MS) / 2;
  localparam int PERSIST_MS = CONFLICT_TRIP_MS;
  localparam int FLASH_HALF_MS = 1000;
  localparam int WDT_TIMEOUT_MS = 1500;
  localparam int CPU_TIMEOUT_MS = 100;
  localparam int RED_SETTLE_MS = 500;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CH_SEL = 8'h04;
  localparam logic [7:0] REG_YEL_INH = 8'h08;
  localparam logic [7:0] REG_MIN_YEL = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_SNAP_GY = 8'h14;
  localparam logic [7:0] REG_SNAP_RC = 8'h18;

  // Field positions and reset values
  localparam int CTRL_WD_EN_BIT = 0;
  localparam logic CTRL_WD_EN_RST = 1'b1;
  localparam logic [15:0] CH_SEL_RST = 16'h0000;
  localparam logic [15:0] YEL_INH_RST = 16'h0000;
  localparam logic [11:0] MIN_YEL_RST = 12'hbb8;

  typedef struct packed {
    logic internal_failure;
    logic yellow_fault;
    logic no_input;
    logic multiple_input;
    logic card_unseated;
    logic controller_wd;
    logic dc_supply;
    logic conflict;
  } sfl_cause_type;

  typedef struct packed {
    logic [NUM_CH-1:0] grn;
    logic [NUM_CH-1:0] yel;
    logic [NUM_CH-1:0] red;
    logic [NUM_CH-1:0][NUM_CH-1:0] compat;
    logic reset_btn;
    logic ext_reset;
    logic line_ok;
    logic dc_ok;
    logic card_seated;
    logic red_monitor_cable_en;
    logic ctrl_wd;
    logic cpu_alive;
    logic mem_test_fail;
  } sfl_pins_type;

  typedef struct packed {
    logic failed;
    sfl_cause_type cause;
    logic [NUM_CH-1:0] chan;
    logic [NUM_CH-1:0] red;
    logic [NUM_CH-1:0] yel;
    logic [NUM_CH-1:0] grn;
  } sfl_record_type;

  typedef struct packed {
    logic line_power_indicator;
    logic dc_supply_fault_indicator;
    logic conflict;
    logic controller_supervision_fault;
    logic card_unseated;
    logic multiple_input;
    logic no_active_input_fault;
    logic yellow_fault;
    logic internal_failure;
  } sfl_ind_type;

endpackage

// File: test/sfl_cabinet_model.sv
// Cabinet heartbeats and power-safe record store facing the fault latch
`timescale 1ns/1ns
module sfl_cabinet_model import sfl_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Scenario controls
  input wire logic wd_stall,
  input wire logic cpu_stall,
  // Record store
  input wire logic nv_wr_en,
  input wire sfl_record_type nv_wr_rec,
  output logic nv_rd_valid,
  output sfl_record_type nv_rd_rec,
  // Heartbeats
  output logic ctrl_wd,
  output logic cpu_alive
);
  logic [7:0] beat_q;

  initial begin
    nv_rd_valid = 1'b0;
    nv_rd_rec = '0;
    beat_q = 8'h00;
  end

  // Store ignores rstn, as a power loss must not erase it
  always @(posedge ref_clk) begin
    if (nv_wr_en === 1'b1) begin
      nv_rd_rec <= nv_wr_rec;
      nv_rd_valid <= 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    beat_q <= beat_q + 8'h01;
  end

  // A stalled source freezes low, as a dead controller would
  assign ctrl_wd = wd_stall ? 1'b0 : beat_q[5];
  assign cpu_alive = cpu_stall ? 1'b0 : beat_q[4];
endmodule

// File: test/test_sfl_fault_latch.sv
// Self-checking bench for the fault latch
`timescale 1ns/1ns
module test_sfl_fault_latch import sfl_pkg::*;;
  logic ref_clk;
  logic rstn;
  sfl_pins_type drv;
  sfl_pins_type pins;
  logic wd_stall, cpu_stall, wd, alive;
  logic nv_rd_valid, nv_wr_en;
  sfl_record_type nv_rd_rec, nv_wr_rec;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed;
  logic reg_wr, reg_rd, rd_q;
  logic relay_coil, stop_time_o, stop_time_oe_n;
  sfl_ind_type ind;
  logic [NUM_CH-1:0] chan_ind;
  logic [31:0] exp_q[$];
  int fails, checks_done, hi, mism;

  sfl_fault_latch #(.MS_CYCLES(4)) sfl_fault_latch_inst (.ref_clk(ref_clk), .rstn(rstn), .pins(pins),
    .nv_rd_valid(nv_rd_valid), .nv_rd_rec(nv_rd_rec), .nv_wr_en(nv_wr_en), .nv_wr_rec(nv_wr_rec),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .relay_coil(relay_coil), .stop_time_o(stop_time_o), .stop_time_oe_n(stop_time_oe_n),
    .ind(ind), .chan_ind(chan_ind));

  sfl_cabinet_model sfl_cabinet_model_inst (.ref_clk(ref_clk), .rstn(rstn), .wd_stall(wd_stall),
    .cpu_stall(cpu_stall), .nv_wr_en(nv_wr_en), .nv_wr_rec(nv_wr_rec), .nv_rd_valid(nv_rd_valid),
    .nv_rd_rec(nv_rd_rec), .ctrl_wd(wd), .cpu_alive(alive));

  always_comb begin
    pins = drv;
    pins.ctrl_wd = wd;
    pins.cpu_alive = alive;
  end

  always #2 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Expectation queued here, compared by the watcher below
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  always @(posedge ref_clk) begin
    rd_q <= reg_rd;
    if (rd_q === 1'b1) check("reg_rdata", reg_rdata, exp_q.pop_front());
  end

  // Reset source is raised and dropped; only its rising edge counts
  task automatic clr(bit ext);
    if (ext) drv.ext_reset <= 1'b1;
    else drv.reset_btn <= 1'b1;
    cyc(6);
    drv.ext_reset <= 1'b0;
    drv.reset_btn <= 1'b0;
    cyc(6);
    check("relay_cleared", 32'(relay_coil), 32'h1);
  endtask

  task automatic is_failed(logic [7:0] im, logic [31:0] s);
    check("relay_coil", 32'(relay_coil), 32'h0);
    check("stop_time_oe_n", 32'(stop_time_oe_n), 32'h0);
    check("fault_ind", 32'(ind[7:0]), 32'(im));
    rd(REG_STATUS, s);
  endtask

  task automatic seq_g2r();
    drv.red <= 16'h0002;
    drv.grn <= 16'h0001;
    cyc(50);
    drv.grn <= 16'h0000;
    drv.red <= 16'h0003;
    cyc(12);
  endtask

  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    drv = '0;
    drv.compat = '1;
    drv.compat[0][1] = 1'b0;
    drv.compat[1][0] = 1'b0;
    drv.line_ok = 1'b1;
    drv.dc_ok = 1'b1;
    drv.card_seated = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, wd_stall, cpu_stall} = '0;
    seed = 32'h1cba0f50;
    cyc(3);
    rstn <= 1'b1;
    cyc(20);
    rd(REG_CTRL, 32'h1);
    rd(REG_CH_SEL, 32'h0);
    rd(REG_YEL_INH, 32'h0);
    rd(REG_MIN_YEL, 32'hbb8);
    rd(8'h20, 32'h0);
    seed = xs(seed);
    wr(REG_CH_SEL, seed);
    rd(REG_CH_SEL, seed & 32'hffff);
    seed = xs(seed);
    wr(REG_MIN_YEL, seed);
    rd(REG_MIN_YEL, seed & 32'hfff);
    wr(REG_STATUS, 32'hffff);
    rd(REG_STATUS, 32'h400);
    check("relay_idle", 32'(relay_coil), 32'h1);
    check("halt_idle", 32'({stop_time_o, stop_time_oe_n}), 32'h1);
    check("line_ind", 32'(ind.line_power_indicator), 32'h1);
    seed = xs(seed);
    drv.grn <= 16'h0003;
    cyc(700 + (seed % 100));
    drv.grn <= 16'h0000;
    cyc(20);
    check("short_conflict", 32'(relay_coil), 32'h1);
    drv.grn <= 16'h0003;
    cyc(1800);
    is_failed(8'h40, 32'h501);
    check("conflict_chan", 32'(chan_ind), 32'h3);
    rd(REG_SNAP_GY, 32'h3);
    check("nv_grn", 32'(nv_rd_rec.grn), 32'h3);
    drv.reset_btn <= 1'b1;
    cyc(10);
    check("held_trip", 32'(relay_coil), 32'h0);
    drv.grn <= 16'h0000;
    cyc(30);
    check("held_level", 32'(relay_coil), 32'h0);
    drv.reset_btn <= 1'b0;
    cyc(10);
    clr(1);
    drv.dc_ok <= 1'b0;
    cyc(10);
    is_failed(8'h80, 32'h502);
    drv.dc_ok <= 1'b1;
    cyc(5);
    rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
    cyc(10);
    is_failed(8'h80, 32'h502);
    clr(0);
    check("nv_cleared", 32'(nv_rd_rec.failed), 32'h0);
    wd_stall <= 1'b1;
    cyc(6200);
    is_failed(8'h20, 32'h504);
    wd_stall <= 1'b0;
    cyc(100);
    clr(1);
    wr(REG_CTRL, 32'h0);
    drv.line_ok <= 1'b0;
    cyc(10);
    hi = 0;
    mism = 0;
    repeat (16000) begin
      @(posedge ref_clk);
      if (ind.controller_supervision_fault === 1'b1) hi++;
      if (ind.line_power_indicator !== ind.controller_supervision_fault) mism++;
      if (ind.no_active_input_fault !== ind.controller_supervision_fault) mism++;
    end
    check("flash_duty", 32'(hi >= 7990 && hi <= 8010), 32'h1);
    check("flash_shared", mism, 32'h0);
    check("flash_nofail", 32'(relay_coil), 32'h1);
    drv.line_ok <= 1'b1;
    wr(REG_CTRL, 32'h1);
    drv.card_seated <= 1'b0;
    cyc(10);
    is_failed(8'h10, 32'h508);
    drv.card_seated <= 1'b1;
    clr(0);
    drv.mem_test_fail <= 1'b1;
    cyc(10);
    is_failed(8'h01, 32'h580);
    drv.mem_test_fail <= 1'b0;
    clr(1);
    cpu_stall <= 1'b1;
    cyc(500);
    is_failed(8'h01, 32'h580);
    cpu_stall <= 1'b0;
    cyc(20);
    clr(0);
    wr(REG_CH_SEL, 32'h3);
    drv.red <= 16'h0003;
    cyc(5);
    drv.red_monitor_cable_en <= 1'b1;
    cyc(2100);
    check("plug_in", 32'(relay_coil), 32'h1);
    rd(REG_STATUS, 32'h600);
    drv.grn <= 16'h0001;
    cyc(1400);
    is_failed(8'h08, 32'h710);
    check("multi_chan", 32'(chan_ind), 32'h1);
    drv.grn <= 16'h0000;
    cyc(10);
    clr(1);
    drv.red <= 16'h0001;
    cyc(1400);
    is_failed(8'h04, 32'h720);
    check("none_chan", 32'(chan_ind), 32'h2);
    drv.red <= 16'h0003;
    cyc(10);
    clr(0);
    seq_g2r();
    is_failed(8'h02, 32'h740);
    clr(1);
    wr(REG_YEL_INH, 32'h1);
    seq_g2r();
    check("yel_inhibit", 32'(relay_coil), 32'h1);
    wr(REG_YEL_INH, 32'h0);
    wr(REG_MIN_YEL, 32'h10);
    drv.red <= 16'h0002;
    drv.yel <= 16'h0001;
    cyc(20);
    drv.yel <= 16'h0000;
    drv.red <= 16'h0003;
    cyc(12);
    is_failed(8'h02, 32'h740);
    check("yel_chan", 32'(chan_ind), 32'h1);
    clr(0);
    drv.red <= 16'h0002;
    drv.yel <= 16'h0001;
    cyc(120);
    drv.yel <= 16'h0000;
    drv.red <= 16'h0003;
    cyc(12);
    check("long_yellow", 32'(relay_coil), 32'h1);
    drv.red_monitor_cable_en <= 1'b0;
    cyc(5);
    drv.red <= 16'h0000;
    cyc(1400);
    check("unplug", 32'(relay_coil), 32'h1);
    give_verdict();
  end

  initial begin
    cyc(60000);
    fails++;
    give_verdict();
  end
endmodule
